//--- common/pfs_pkg.sv
package pfs_pkg;

	// ------------------------------------------------------------
	// Register addresses and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PFS_P0_UPPER_ADDR  = 8'hE6;
	localparam logic [7:0] PFS_P0_LOWER_ADDR  = 8'hE7;
	localparam logic [7:0] PFS_P1_UPPER_ADDR  = 8'hE8;
	localparam logic [7:0] PFS_P1_LOWER_ADDR  = 8'hE9;
	localparam logic [7:0] PFS_P0_UPPER_RESET = 8'h00;
	localparam logic [7:0] PFS_P0_LOWER_RESET = 8'h0F;
	localparam logic [7:0] PFS_P1_UPPER_RESET = 8'h00;
	localparam logic [7:0] PFS_P1_LOWER_RESET = 8'h00;
	localparam logic [7:0] PFS_P1_UPPER_MASK  = 8'h0F;
	localparam logic [7:0] PFS_UNMAPPED_READ  = 8'h00;

	// ------------------------------------------------------------
	// Field layout and mode codes
	// ------------------------------------------------------------
	localparam int         PFS_FIELD_W      = 2;
	localparam int         PFS_P0_PINS      = 8;
	localparam int         PFS_P1_PINS      = 6;
	localparam logic [1:0] PFS_MODE_PULLUP  = 2'h0;
	localparam logic [1:0] PFS_MODE_INPUT   = 2'h1;
	localparam logic [1:0] PFS_MODE_OUTPUT  = 2'h2;
	localparam logic [1:0] PFS_MODE_ALT     = 2'h3;
	localparam logic       PFS_RX_IDLE      = 1'b1;

	// ------------------------------------------------------------
	// Pin kinds
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PFS_KIND_GPIO,
		PFS_KIND_ALT_OUT,
		PFS_KIND_ALT_IN
	} pfs_kind_t;

	localparam pfs_kind_t PFS_P0_KIND [0:7] = '{PFS_KIND_ALT_IN, PFS_KIND_ALT_OUT, PFS_KIND_GPIO,
		PFS_KIND_GPIO, PFS_KIND_ALT_OUT, PFS_KIND_GPIO, PFS_KIND_GPIO, PFS_KIND_GPIO};
	localparam pfs_kind_t PFS_P1_KIND [0:5] = '{PFS_KIND_ALT_OUT, PFS_KIND_GPIO, PFS_KIND_ALT_OUT,
		PFS_KIND_ALT_OUT, PFS_KIND_ALT_OUT, PFS_KIND_ALT_OUT};

endpackage

//--- src/pfs_pin_cell.sv
`timescale 1ns/10ps
module pfs_pin_cell #(
	parameter pfs_pkg::pfs_kind_t KIND = pfs_pkg::PFS_KIND_GPIO
) (
	input  wire logic [1:0] mode,
	input  wire logic       gpio_out,
	input  wire logic       alt_out,
	output logic            next_out,
	output logic            next_oe,
	output logic            next_pull,
	output logic            next_in_en,
	output logic            next_alt_in_en
);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// Code 11 only means an alternate function on pins that have one
	always_comb begin
		next_out       = 1'b0;
		next_oe        = 1'b0;
		next_pull      = 1'b0;
		next_in_en     = 1'b0;
		next_alt_in_en = 1'b0;
		case (mode)
			pfs_pkg::PFS_MODE_PULLUP: begin
				next_pull  = 1'b1;
				next_in_en = 1'b1;
			end
			pfs_pkg::PFS_MODE_INPUT: begin
				next_in_en = 1'b1;
			end
			pfs_pkg::PFS_MODE_OUTPUT: begin
				next_oe  = 1'b1;
				next_out = gpio_out;
			end
			pfs_pkg::PFS_MODE_ALT: begin
				if (KIND == pfs_pkg::PFS_KIND_ALT_OUT) begin
					next_oe  = 1'b1;
					next_out = alt_out;
				end else if (KIND == pfs_pkg::PFS_KIND_ALT_IN) begin
					next_alt_in_en = 1'b1;
				end else begin
					next_oe  = 1'b1;
					next_out = gpio_out;
				end
			end
			default: begin
				next_oe = 1'b0;
			end
		endcase
	end

endmodule

//--- src/pfs_top.sv
// Operation
// - Port 0 pin 7 field: 00 pulled-up input to timer A capture, 01 plain input to it, 1X push-pull output.
// - Port 0 pin 5 field: 00 pulled-up input to timer 1 capture 0, 01 plain input to it, 1X push-pull output.
// - Port 0 pin 4 field: 00 pulled-up input, 01 input, 10 push-pull output, 11 driven by timer 1 output 1.
// - Port 0 lower bits 7-6 set pin 3: 00 pulled-up to timer 1 clock 1, 01 plain input to it, 1X output.
// - Port 1 pin 4 field: 00 pulled-up serial receive, 01 plain receive, 10 output, 11 receive-line output.
// - Port 1 lower bits 3-2 set pin 1: 00 pulled-up to timer 1 clock 0, 01 plain input to it, 1X output.
`timescale 1ns/10ps
module pfs_top #(
	parameter logic [7:0] P1_UPPER_ADDR = pfs_pkg::PFS_P1_UPPER_ADDR,
	parameter logic [7:0] P1_LOWER_ADDR = pfs_pkg::PFS_P1_LOWER_ADDR
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd_en,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] port0_gpio_out,
	input  wire logic [5:0] port1_gpio_out,
	input  wire logic       timer1_output_ch1,
	input  wire logic       sub_osc_drive,
	input  wire logic       serial_tx_out,
	input  wire logic       serial_rx_line_out,
	input  wire logic       buzzer_output,
	input  wire logic       timer1_output_ch0,
	input  wire logic       timer_a_output,
	input  wire logic [7:0] port0_pin_in,
	input  wire logic [5:0] port1_pin_in,
	output logic      [7:0] port0_pin_out,
	output logic      [7:0] port0_pin_oe,
	output logic      [7:0] port0_pull_en,
	output logic      [5:0] port1_pin_out,
	output logic      [5:0] port1_pin_oe,
	output logic      [5:0] port1_pull_en,
	output logic      [7:0] port0_in_data,
	output logic      [5:0] port1_in_data,
	output logic            timer_a_capture_in,
	output logic            timer_a_clock_in,
	output logic            timer1_capture_in_ch0,
	output logic            timer1_capture_in_ch1,
	output logic            timer1_clock_in_1,
	output logic            timer1_clock_in_0,
	output logic            serial_rx_in,
	output logic            sub_osc_sense_pin
);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [7:0] port0_upper_pin_mode;
	logic [7:0] port0_lower_pin_mode;
	logic [7:0] port1_upper_pin_mode;
	logic [7:0] port1_lower_pin_mode;

	// Only a direct register address port exists, so no other mode can reach them
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port0_upper_pin_mode <= pfs_pkg::PFS_P0_UPPER_RESET;
			port0_lower_pin_mode <= pfs_pkg::PFS_P0_LOWER_RESET;
			port1_upper_pin_mode <= pfs_pkg::PFS_P1_UPPER_RESET;
			port1_lower_pin_mode <= pfs_pkg::PFS_P1_LOWER_RESET;
		end else if (reg_wr_en) begin
			if (reg_addr == pfs_pkg::PFS_P0_UPPER_ADDR) begin
				port0_upper_pin_mode <= reg_wdata;
			end
			if (reg_addr == pfs_pkg::PFS_P0_LOWER_ADDR) begin
				port0_lower_pin_mode <= reg_wdata;
			end
			if (reg_addr == P1_UPPER_ADDR) begin
				port1_upper_pin_mode <= reg_wdata & pfs_pkg::PFS_P1_UPPER_MASK;
			end
			if (reg_addr == P1_LOWER_ADDR) begin
				port1_lower_pin_mode <= reg_wdata;
			end
		end
	end

	// Unused upper bits of port 1 upper register read as zero
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reg_rdata <= pfs_pkg::PFS_UNMAPPED_READ;
		end else if (reg_rd_en) begin
			if (reg_addr == pfs_pkg::PFS_P0_UPPER_ADDR) begin
				reg_rdata <= port0_upper_pin_mode;
			end else if (reg_addr == pfs_pkg::PFS_P0_LOWER_ADDR) begin
				reg_rdata <= port0_lower_pin_mode;
			end else if (reg_addr == P1_UPPER_ADDR) begin
				reg_rdata <= port1_upper_pin_mode;
			end else if (reg_addr == P1_LOWER_ADDR) begin
				reg_rdata <= port1_lower_pin_mode;
			end else begin
				reg_rdata <= pfs_pkg::PFS_UNMAPPED_READ;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	logic [7:0] port0_meta;
	logic [7:0] port0_sync;
	logic [5:0] port1_meta;
	logic [5:0] port1_sync;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port0_meta <= 8'h00;
			port0_sync <= 8'h00;
			port1_meta <= 6'h00;
			port1_sync <= 6'h00;
		end else begin
			port0_meta <= port0_pin_in;
			port0_sync <= port0_meta;
			port1_meta <= port1_pin_in;
			port1_sync <= port1_meta;
		end
	end

	// ------------------------------------------------------------
	// Per-pin decode
	// ------------------------------------------------------------
	logic [15:0] port0_mode_vec;
	logic [11:0] port1_mode_vec;
	logic [7:0]  port0_alt_vec;
	logic [5:0]  port1_alt_vec;
	logic [7:0]  next_port0_out;
	logic [7:0]  next_port0_oe;
	logic [7:0]  next_port0_pull;
	logic [7:0]  port0_in_en;
	logic [7:0]  port0_alt_in_en;
	logic [5:0]  next_port1_out;
	logic [5:0]  next_port1_oe;
	logic [5:0]  next_port1_pull;
	logic [5:0]  port1_in_en;
	logic [5:0]  port1_alt_in_en;

	assign port0_mode_vec = {port0_upper_pin_mode, port0_lower_pin_mode};
	assign port1_mode_vec = {port1_upper_pin_mode[3:0], port1_lower_pin_mode};
	assign port0_alt_vec  = {3'h0, timer1_output_ch1, 2'h0, sub_osc_drive, 1'b0};
	assign port1_alt_vec  = {serial_tx_out, serial_rx_line_out, buzzer_output,
		timer1_output_ch0, 1'b0, timer_a_output};

	genvar gi;
	generate
		for (gi = 0; gi < pfs_pkg::PFS_P0_PINS; gi++) begin : g_port0
			pfs_pin_cell #(
				.KIND(pfs_pkg::PFS_P0_KIND[gi])
			) u_cell (
				.mode           (port0_mode_vec[gi*pfs_pkg::PFS_FIELD_W +: pfs_pkg::PFS_FIELD_W]),
				.gpio_out       (port0_gpio_out[gi]),
				.alt_out        (port0_alt_vec[gi]),
				.next_out       (next_port0_out[gi]),
				.next_oe        (next_port0_oe[gi]),
				.next_pull      (next_port0_pull[gi]),
				.next_in_en     (port0_in_en[gi]),
				.next_alt_in_en (port0_alt_in_en[gi])
			);
		end
		for (gi = 0; gi < pfs_pkg::PFS_P1_PINS; gi++) begin : g_port1
			pfs_pin_cell #(
				.KIND(pfs_pkg::PFS_P1_KIND[gi])
			) u_cell (
				.mode           (port1_mode_vec[gi*pfs_pkg::PFS_FIELD_W +: pfs_pkg::PFS_FIELD_W]),
				.gpio_out       (port1_gpio_out[gi]),
				.alt_out        (port1_alt_vec[gi]),
				.next_out       (next_port1_out[gi]),
				.next_oe        (next_port1_oe[gi]),
				.next_pull      (next_port1_pull[gi]),
				.next_in_en     (port1_in_en[gi]),
				.next_alt_in_en (port1_alt_in_en[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Pin drive registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port0_pin_out <= 8'h00;
			port0_pin_oe  <= 8'h00;
			port0_pull_en <= 8'h00;
			port1_pin_out <= 6'h00;
			port1_pin_oe  <= 6'h00;
			port1_pull_en <= 6'h00;
		end else begin
			port0_pin_out <= next_port0_out;
			port0_pin_oe  <= next_port0_oe;
			port0_pull_en <= next_port0_pull;
			port1_pin_out <= next_port1_out;
			port1_pin_oe  <= next_port1_oe;
			port1_pull_en <= next_port1_pull;
		end
	end

	// ------------------------------------------------------------
	// Peripheral input routing
	// ------------------------------------------------------------
	// Outside input mode peripherals see a quiet level, never the pin's own drive
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port0_in_data         <= 8'h00;
			port1_in_data         <= 6'h00;
			timer_a_capture_in    <= 1'b0;
			timer_a_clock_in      <= 1'b0;
			timer1_capture_in_ch0 <= 1'b0;
			timer1_capture_in_ch1 <= 1'b0;
			timer1_clock_in_1     <= 1'b0;
			timer1_clock_in_0     <= 1'b0;
			serial_rx_in          <= pfs_pkg::PFS_RX_IDLE;
			sub_osc_sense_pin     <= 1'b0;
		end else begin
			port0_in_data         <= port0_sync;
			port1_in_data         <= port1_sync;
			timer_a_capture_in    <= port0_sync[7] & port0_in_en[7];
			timer_a_clock_in      <= port0_sync[6] & port0_in_en[6];
			timer1_capture_in_ch0 <= port0_sync[5] & port0_in_en[5];
			timer1_clock_in_1     <= port0_sync[3] & port0_in_en[3];
			timer1_capture_in_ch1 <= port0_sync[2] & port0_in_en[2];
			timer1_clock_in_0     <= port1_sync[1] & port1_in_en[1];
			serial_rx_in          <= port1_in_en[4] ? port1_sync[4] : pfs_pkg::PFS_RX_IDLE;
			sub_osc_sense_pin     <= port0_sync[0] & port0_alt_in_en[0];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	chk_p07_capture_route: assert property (
		$past(port0_upper_pin_mode[7]) == 1'b0 |-> timer_a_capture_in == $past(port0_sync[7]))
		else $error("Pin 0.7 input not routed to timer A capture");
	chk_p07_push_pull: assert property (
		$past(port0_upper_pin_mode[7]) |-> port0_pin_oe[7] && port0_pin_out[7] == $past(port0_gpio_out[7]))
		else $error("Pin 0.7 output mode wrong");
	chk_p05_pull_up: assert property (
		$past(rst_b) && $past(port0_upper_pin_mode[3:2]) == 2'h0 |-> port0_pull_en[5] && !port0_pin_oe[5])
		else $error("Pin 0.5 pull-up input wrong");
	chk_p04_timer_out: assert property (
		$past(port0_upper_pin_mode[1:0]) == 2'h3 |-> port0_pin_oe[4] && port0_pin_out[4] == $past(timer1_output_ch1))
		else $error("Pin 0.4 not driven by timer output");
	chk_p03_plain_input: assert property (
		$past(port0_lower_pin_mode[7:6]) == 2'h1
		|-> !port0_pull_en[3] && !port0_pin_oe[3] && timer1_clock_in_1 == $past(port0_sync[3]))
		else $error("Pin 0.3 plain input wrong");
	chk_p02_output_gate: assert property (
		$past(port0_lower_pin_mode[5]) |-> port0_pin_oe[2] && !timer1_capture_in_ch1)
		else $error("Pin 0.2 output mode wrong");
	chk_p14_rx_line: assert property (
		$past(port1_upper_pin_mode[1:0]) == 2'h3 |-> port1_pin_oe[4] && port1_pin_out[4] == $past(serial_rx_line_out))
		else $error("Pin 1.4 receive-line output wrong");
	chk_p11_pull_input: assert property (
		$past(rst_b) && $past(port1_lower_pin_mode[3:2]) == 2'h0 |-> port1_pull_en[1] && !port1_pin_oe[1])
		else $error("Pin 1.1 pull-up input wrong");
	chk_lower_reset_value: assert property (
		$past(rst_b) == 1'b0 |-> port0_lower_pin_mode == pfs_pkg::PFS_P0_LOWER_RESET ##1 port0_pin_oe[1])
		else $error("Port 0 lower reset value wrong");
	chk_p13_buzzer_out: assert property (
		$past(port1_lower_pin_mode[7:6]) == 2'h3 |-> port1_pin_oe[3] && port1_pin_out[3] == $past(buzzer_output))
		else $error("Pin 1.3 not driven by buzzer");

endmodule

//--- tb/pfs_board_pins.sv
`timescale 1ns/10ps
module pfs_board_pins #(
	parameter int N = 8
) (
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	input  wire logic [N-1:0] pull_en,
	input  wire logic [N-1:0] ext_drive,
	output logic      [N-1:0] level
);
	// ------------------------------------------------------------
	// Board wire resolution
	// ------------------------------------------------------------
	// Driver wins, then pull-up; a bare pin shows the board's own level
	always_comb begin
		for (int i = 0; i < N; i++) begin
			level[i] = pin_oe[i] ? pin_out[i] : (pull_en[i] ? 1'b1 : ext_drive[i]);
		end
	end
endmodule

//--- tb/port_pin_function_select_bench.sv
`timescale 1ns/10ps
module port_pin_function_select_bench;
	logic       sys_clk;
	logic       rst_b;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] p0_gpio;
	logic [7:0] p0_ext;
	logic [7:0] p0_lvl;
	logic [7:0] p0_out;
	logic [7:0] p0_oe;
	logic [7:0] p0_pull;
	logic [7:0] p0_in;
	logic [5:0] p1_gpio;
	logic [5:0] p1_ext;
	logic [5:0] p1_lvl;
	logic [5:0] p1_out;
	logic [5:0] p1_oe;
	logic [5:0] p1_pull;
	logic [5:0] p1_in;
	logic [6:0] alt_src;
	logic [7:0] periph;
	logic [7:0] r_p0u;
	logic [7:0] r_p0l;
	logic [7:0] r_p1u;
	logic [7:0] r_p1l;
	int         fails;
	int         samples_checked;
	int         seed;

	pfs_top DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .port0_gpio_out(p0_gpio),
		.port1_gpio_out(p1_gpio), .timer1_output_ch1(alt_src[0]), .sub_osc_drive(alt_src[1]),
		.serial_tx_out(alt_src[2]), .serial_rx_line_out(alt_src[3]), .buzzer_output(alt_src[4]),
		.timer1_output_ch0(alt_src[5]), .timer_a_output(alt_src[6]), .port0_pin_in(p0_lvl),
		.port1_pin_in(p1_lvl), .port0_pin_out(p0_out), .port0_pin_oe(p0_oe), .port0_pull_en(p0_pull),
		.port1_pin_out(p1_out), .port1_pin_oe(p1_oe), .port1_pull_en(p1_pull), .port0_in_data(p0_in),
		.port1_in_data(p1_in), .timer_a_capture_in(periph[7]), .timer_a_clock_in(periph[6]),
		.timer1_capture_in_ch0(periph[5]), .timer1_clock_in_1(periph[4]),
		.timer1_capture_in_ch1(periph[3]), .timer1_clock_in_0(periph[2]), .serial_rx_in(periph[1]),
		.sub_osc_sense_pin(periph[0]));
	pfs_board_pins #(.N(8)) board0 (.pin_out(p0_out), .pin_oe(p0_oe), .pull_en(p0_pull),
		.ext_drive(p0_ext), .level(p0_lvl));
	pfs_board_pins #(.N(6)) board1 (.pin_out(p1_out), .pin_oe(p1_oe), .pull_en(p1_pull),
		.ext_drive(p1_ext), .level(p1_lvl));

	// ------------------------------------------------------------
	// Shared tasks and expectation functions
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Register addressing only: one address phase per access
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_wr_en = 1'b0;
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(posedge sys_clk);
		#1;
		check("reg_rdata", exp, reg_rdata);
	endtask

	// Returns {oe, out, pull}; out only meaningful while oe is set
	function automatic logic [2:0] exp_pin(input logic [1:0] m, input pfs_pkg::pfs_kind_t k,
		input logic g, input logic a);
		if (m == pfs_pkg::PFS_MODE_PULLUP) return 3'b001;
		if (m == pfs_pkg::PFS_MODE_INPUT) return 3'b000;
		if (m == pfs_pkg::PFS_MODE_ALT && k == pfs_pkg::PFS_KIND_ALT_IN) return 3'b000;
		if (m == pfs_pkg::PFS_MODE_ALT && k == pfs_pkg::PFS_KIND_ALT_OUT) return {1'b1, a, 1'b0};
		return {1'b1, g, 1'b0};
	endfunction

	task automatic check_all();
		logic [15:0] m0;
		logic [11:0] m1;
		logic [7:0]  a0;
		logic [5:0]  a1;
		logic [2:0]  e;
		logic [7:0]  oe0, out0, pu0, lv0, ep;
		logic [5:0]  oe1, out1, pu1, lv1;
		m0 = {r_p0u, r_p0l};
		m1 = {r_p1u[3:0], r_p1l};
		a0 = {3'b000, alt_src[0], 2'b00, alt_src[1], 1'b0};
		a1 = {alt_src[2], alt_src[3], alt_src[4], alt_src[5], 1'b0, alt_src[6]};
		for (int i = 0; i < 8; i++) begin
			e = exp_pin(m0[2*i+:2], pfs_pkg::PFS_P0_KIND[i], p0_gpio[i], a0[i]);
			{oe0[i], out0[i], pu0[i]} = e;
			lv0[i] = e[2] ? e[1] : (e[0] | p0_ext[i]);
		end
		for (int i = 0; i < 6; i++) begin
			e = exp_pin(m1[2*i+:2], pfs_pkg::PFS_P1_KIND[i], p1_gpio[i], a1[i]);
			{oe1[i], out1[i], pu1[i]} = e;
			lv1[i] = e[2] ? e[1] : (e[0] | p1_ext[i]);
		end
		ep = {~m0[15] & lv0[7], ~m0[13] & lv0[6], ~m0[11] & lv0[5], ~m0[7] & lv0[3],
			~m0[5] & lv0[2], ~m1[3] & lv1[1], m1[9] | lv1[4], (&m0[1:0]) & lv0[0]};
		check("port0_pin_oe", oe0, p0_oe);
		check("port0_pin_out", out0 & oe0, p0_out & oe0);
		check("port0_pull_en", pu0, p0_pull);
		check("port1_pin_oe", {2'b00, oe1}, {2'b00, p1_oe});
		check("port1_pin_out", {2'b00, out1 & oe1}, {2'b00, p1_out & oe1});
		check("port1_pull_en", {2'b00, pu1}, {2'b00, p1_pull});
		check("peripheral_inputs", ep, periph);
		check("port0_in_data", lv0, p0_in);
		check("port1_in_data", {2'b00, lv1}, {2'b00, p1_in});
	endtask

	task automatic reg_chk();
		rd(pfs_pkg::PFS_P0_UPPER_ADDR, r_p0u);
		rd(pfs_pkg::PFS_P0_LOWER_ADDR, r_p0l);
		rd(pfs_pkg::PFS_P1_UPPER_ADDR, r_p1u & pfs_pkg::PFS_P1_UPPER_MASK);
		rd(pfs_pkg::PFS_P1_LOWER_ADDR, r_p1l);
		rd(8'hE5, pfs_pkg::PFS_UNMAPPED_READ);
		// Strobe held across the burst, dropped once after the last read
		reg_rd_en = 1'b0;
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Corner patterns first so every code reaches every field
	initial begin
		logic [7:0] corner [0:3];
		corner = '{8'h00, 8'h55, 8'hAA, 8'hFF};
		seed = 32'h692a23e8;
		fails = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		p0_gpio = 8'h00;
		p1_gpio = 6'h00;
		p0_ext = 8'h00;
		p1_ext = 6'h00;
		alt_src = 7'h00;
		r_p0u = pfs_pkg::PFS_P0_UPPER_RESET;
		r_p0l = pfs_pkg::PFS_P0_LOWER_RESET;
		r_p1u = pfs_pkg::PFS_P1_UPPER_RESET;
		r_p1l = pfs_pkg::PFS_P1_LOWER_RESET;
		repeat (10) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		check_all();
		reg_chk();
		$display("Test reset done");
		for (int t = 0; t < 40; t++) begin
			r_p0u = (t < 4) ? corner[t] : 8'($random(seed));
			r_p0l = (t < 4) ? corner[t] : 8'($random(seed));
			r_p1u = (t < 4) ? corner[t] : 8'($random(seed));
			r_p1l = (t < 4) ? corner[t] : 8'($random(seed));
			p0_gpio = 8'($random(seed));
			p1_gpio = 6'($random(seed));
			p0_ext = 8'($random(seed));
			p1_ext = 6'($random(seed));
			alt_src = 7'($random(seed));
			// Back to back writes, one per cycle
			wr(pfs_pkg::PFS_P0_UPPER_ADDR, r_p0u);
			wr(pfs_pkg::PFS_P0_LOWER_ADDR, r_p0l);
			wr(pfs_pkg::PFS_P1_UPPER_ADDR, r_p1u);
			wr(pfs_pkg::PFS_P1_LOWER_ADDR, r_p1l);
			wr(8'hE5, 8'($random(seed)));
			reg_wr_en = 1'b0;
			repeat (5) @(posedge sys_clk);
			#1;
			check_all();
			reg_chk();
			$display("Test %0d done", t);
		end
		print_verdict();
	end
endmodule
